// ### mpr_unit.sv
// Memory protect and relocate unit between processor and core memory
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module mpr_unit
    import mpr_pkg::*;
#(
    parameter int PROT_CYCLES = PROT_CYC,
    parameter int WR_CYCLES   = WR_CYC
)(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire mpr_req_t          cpu_req,
    output logic                   cpu_ready,
    output logic                   cpu_trap,
    output mpr_mem_t               mem_cyc,
    output logic                   viol_irq,
    output logic                   user_mode
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mpr_state_t        st;
        logic [CNT_W-1:0]  cnt;
        logic              user;
        logic              reloc_en;
        logic [BLK_W-1:0]  bound;
        logic [BLK_W-1:0]  reloc;
        logic [BLK_W-1:0]  upper;
        logic              viol;
        mpr_cause_t        cause;
        logic              trap;
        mpr_mem_t          mem;
        logic [DATA_W-1:0] rdata;
    } mpr_regs_t;

    mpr_regs_t s_q;
    mpr_regs_t s_d;

    localparam logic [CNT_W-1:0] PROT_N = CNT_W'(PROT_CYCLES);
    localparam logic [CNT_W-1:0] WR_N   = CNT_W'(PROT_CYCLES + WR_CYCLES);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
        blk_of = a[ADDR_W-1:PAGE_SHIFT];
    endfunction : blk_of

    function automatic mpr_cause_t classify(input mpr_req_t r, input logic rel,
                                            input logic [BLK_W-1:0] bnd,
                                            input logic [BLK_W-1:0] upr);
        classify = CAUSE_NONE;
        if (r.io_transfer_instruction)
            classify = CAUSE_IO_XFER;
        else if (r.halt)
            classify = CAUSE_HALT;
        else if (r.chain_xct)
            classify = CAUSE_XCT;
        else if (r.unit_access)
            classify = CAUSE_UNIT;
        else if (rel && (blk_of(r.addr) > upr))
            classify = CAUSE_BOUND;
        else if (!rel && (blk_of(r.addr) < bnd))
            classify = CAUSE_PROT;
    endfunction : classify

    mpr_cause_t cause_now;
    logic       bad_now;
    logic [ADDR_W-1:0] phys;

    always_comb
    begin
        cause_now = classify(cpu_req, s_q.reloc_en, s_q.bound, s_q.upper);
        bad_now   = s_q.user && cpu_req.valid && (cause_now != CAUSE_NONE);
        // Relocated address wraps at the top of memory
        phys      = cpu_req.addr;
        if (s_q.user && s_q.reloc_en)
            phys = cpu_req.addr + {s_q.reloc, {PAGE_SHIFT{1'b0}}};
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d          = s_q;
        s_d.trap     = 1'b0;
        s_d.mem      = '0;
        s_d.rdata    = '0;
        if (reg_wr)
        begin
            case (reg_addr)
                REG_CTRL:
                begin
                    s_d.user     = reg_wdata[CTRL_USER_BIT];
                    s_d.reloc_en = reg_wdata[CTRL_RELOC_BIT];
                end
                REG_BOUND: s_d.bound = reg_wdata[BLK_W-1:0];
                REG_RELOC: s_d.reloc = reg_wdata[BLK_W-1:0];
                REG_UPPER: s_d.upper = reg_wdata[BLK_W-1:0];
                REG_STATUS:
                begin
                    if (reg_wdata[STAT_VIOL_BIT])
                        s_d.viol = 1'b0;
                end
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                REG_CTRL:   s_d.rdata = DATA_W'({s_q.reloc_en, s_q.user});
                REG_BOUND:  s_d.rdata = DATA_W'(s_q.bound);
                REG_RELOC:  s_d.rdata = DATA_W'(s_q.reloc);
                REG_UPPER:  s_d.rdata = DATA_W'(s_q.upper);
                REG_STATUS: s_d.rdata = DATA_W'({s_q.cause, s_q.viol, s_q.user});
                default:    s_d.rdata = '0;
            endcase
        end
        case (s_q.st)
            ST_IDLE:
            begin
                // Refused request still stands in the trap cycle; skip it
                if (cpu_req.valid && !s_q.trap)
                begin
                    if (bad_now)
                    begin
                        s_d.user  = 1'b0;
                        s_d.viol  = 1'b1;
                        s_d.cause = cause_now;
                        s_d.trap  = 1'b1;
                    end
                    else
                    begin
                        s_d.st  = ST_WAIT;
                        s_d.cnt = (s_q.user && cpu_req.write) ? WR_N : PROT_N;
                    end
                end
            end
            ST_WAIT:
            begin
                s_d.cnt = s_q.cnt - CNT_W'(1);
                if (s_q.cnt == CNT_W'(1))
                    s_d.st = ST_GO;
            end
            ST_GO:
            begin
                s_d.st        = ST_IDLE;
                s_d.mem.valid = 1'b1;
                s_d.mem.write = cpu_req.write;
                s_d.mem.addr  = phys;
                s_d.mem.wdata = cpu_req.wdata;
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q          <= '0;
            s_q.st       <= ST_IDLE;
            s_q.bound    <= BOUND_RST;
            s_q.upper    <= UPPER_RST;
            s_q.cause    <= CAUSE_NONE;
        end
        else if (clk_en)
            s_q <= s_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cpu_ready = clk_en && (s_q.st == ST_GO);
    assign cpu_trap  = s_q.trap;
    assign mem_cyc   = s_q.mem;
    assign viol_irq  = s_q.viol;
    assign user_mode = s_q.user;
    assign reg_rdata = s_q.rdata;

    // ------------------------------------------------------------
    // Checks on the design
    // ------------------------------------------------------------
    chk_trap_leaves_user: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.trap |-> !s_q.user && s_q.viol)
        else $error("trap did not drop to monitor mode");

    chk_bad_no_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && bad_now |=> s_q.st == ST_IDLE && !mem_cyc.valid)
        else $error("violating request started a memory cycle");

    chk_monitor_no_trap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && !s_q.user |=> !cpu_trap)
        else $error("trap raised in monitor mode");

    chk_io_xfer_traps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && s_q.user && cpu_req.valid
        && cpu_req.io_transfer_instruction |=> cpu_trap && s_q.cause == CAUSE_IO_XFER)
        else $error("io transfer in user mode did not trap");

    chk_prot_region: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && s_q.user && !s_q.reloc_en && cpu_req.valid
        && blk_of(cpu_req.addr) < s_q.bound |=> cpu_trap)
        else $error("protected region reference passed");

    chk_upper_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && s_q.user && s_q.reloc_en && cpu_req.valid
        && blk_of(cpu_req.addr) > s_q.upper |=> cpu_trap)
        else $error("reference above upper boundary passed");

    chk_wait_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && cpu_req.valid && !s_q.trap && !bad_now
        |=> s_q.cnt >= PROT_N)
        else $error("memory cycle not stretched");

    chk_user_wr_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && cpu_req.valid && !bad_now && s_q.user && cpu_req.write
        |=> s_q.cnt == WR_N)
        else $error("user write not stretched further");

    chk_reloc_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_GO && s_q.user && s_q.reloc_en
        |=> mem_cyc.addr == ADDR_W'($past(cpu_req.addr) + {$past(s_q.reloc), 8'h00}))
        else $error("relocated address wrong");

    chk_trap_one_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.trap |=> !s_q.trap)
        else $error("trap pulse longer than one cycle");

    chk_viol_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.viol
        && !(reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_VIOL_BIT]) |=> s_q.viol)
        else $error("violation flag lost without a clear");

    chk_viol_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && bad_now |=> viol_irq)
        else $error("violation did not raise the interrupt");

    chk_bound_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == REG_BOUND
        |=> s_q.bound == BLK_W'($past(reg_wdata)))
        else $error("boundary write did not take");

    chk_reloc_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == REG_RELOC
        |=> s_q.reloc == BLK_W'($past(reg_wdata)))
        else $error("relocation write did not take");

    chk_upper_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == REG_UPPER
        |=> s_q.upper == BLK_W'($past(reg_wdata)))
        else $error("upper boundary write did not take");

    chk_page_offset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_GO
        |=> mem_cyc.addr[PAGE_SHIFT-1:0] == PAGE_SHIFT'($past(cpu_req.addr)))
        else $error("offset inside the page altered");

    chk_monitor_flat: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_GO && !s_q.user
        |=> mem_cyc.addr == $past(cpu_req.addr))
        else $error("address changed in monitor mode");

    chk_plain_user_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_GO && s_q.user && !s_q.reloc_en
        |=> mem_cyc.addr == $past(cpu_req.addr))
        else $error("address moved without relocation");

    chk_write_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_GO
        |=> mem_cyc.wdata == $past(cpu_req.wdata) && mem_cyc.write == $past(cpu_req.write))
        else $error("memory cycle carries wrong data");

    chk_ready_issues: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && cpu_ready |=> mem_cyc.valid)
        else $error("accepted request issued no memory cycle");

    chk_halt_traps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && s_q.user && cpu_req.valid && cpu_req.halt
        |=> cpu_trap)
        else $error("halt in user mode did not trap");

    chk_xct_traps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && s_q.user && cpu_req.valid && cpu_req.chain_xct
        |=> cpu_trap)
        else $error("chained execute in user mode did not trap");

    chk_unit_traps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && s_q.user && cpu_req.valid && cpu_req.unit_access
        |=> cpu_trap)
        else $error("unit access in user mode did not trap");

    chk_user_enter: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_USER_BIT]
        && !(s_q.st == ST_IDLE && bad_now) |=> user_mode)
        else $error("control write did not enter user mode");

    chk_mon_wr_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && cpu_req.valid && !s_q.trap && !s_q.user
        |=> s_q.cnt == PROT_N)
        else $error("monitor cycle stretched like a user write");

    chk_user_rd_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_IDLE && cpu_req.valid && !bad_now
        && s_q.user && !cpu_req.write |=> s_q.cnt == PROT_N)
        else $error("user read stretched like a write");

    chk_wait_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s_q.st == ST_WAIT && s_q.cnt != CNT_W'(1)
        |=> s_q.st == ST_WAIT)
        else $error("memory cycle wait ended early");

    cov_user_trap:  cover property (@(posedge sys_clk) disable iff (!rst_n) cpu_trap);
    cov_user_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
        mem_cyc.valid && mem_cyc.write && s_q.user);
    cov_reloc_cyc:  cover property (@(posedge sys_clk) disable iff (!rst_n)
        mem_cyc.valid && s_q.reloc_en && s_q.user);
    cov_bound_trap: cover property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_trap && s_q.cause == CAUSE_BOUND);
    cov_prot_trap:  cover property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_trap && s_q.cause == CAUSE_PROT);

endmodule : mpr_unit

// ### mpr_pkg.sv
// Package for the memory protect and relocate unit
package mpr_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int ADDR_W          = 17;
    localparam int DATA_W          = 18;
    localparam int PAGE_SHIFT      = 8;
    localparam int BLK_W           = ADDR_W - PAGE_SHIFT;
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int PROT_DELAY_PS   = 30000;
    localparam int WR_DELAY_PS     = 175000;
    localparam int PROT_CYC        = (PROT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_CYC          = (WR_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W           = 6;

    // ------------------------------------------------------------
    // Register map, reached over the plain register port
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_BOUND    = 4'h1;
    localparam logic [3:0] REG_RELOC    = 4'h2;
    localparam logic [3:0] REG_UPPER    = 4'h3;
    localparam logic [3:0] REG_STATUS   = 4'h4;
    localparam int CTRL_USER_BIT        = 0;
    localparam int CTRL_RELOC_BIT       = 1;
    localparam int STAT_USER_BIT        = 0;
    localparam int STAT_VIOL_BIT        = 1;
    localparam int STAT_CAUSE_LSB       = 2;
    localparam logic [BLK_W-1:0] BOUND_RST = 9'h000;
    localparam logic [BLK_W-1:0] UPPER_RST = 9'h1ff;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CAUSE_NONE    = 3'h0,
        CAUSE_IO_XFER = 3'h1,
        CAUSE_HALT    = 3'h2,
        CAUSE_XCT     = 3'h3,
        CAUSE_PROT    = 3'h4,
        CAUSE_BOUND   = 3'h5,
        CAUSE_UNIT    = 3'h6
    } mpr_cause_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_GO   = 2'b11
    } mpr_state_t;

    // Request from the processor side of the memory bus
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              io_transfer_instruction;
        logic              halt;
        logic              chain_xct;
        logic              unit_access;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mpr_req_t;

    // Cycle to core memory
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mpr_mem_t;

endpackage : mpr_pkg

// ### mpr_core_model.sv
// Core memory model on the far side of the protect unit
`timescale 1ns/1ps
module mpr_core_model
    import mpr_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire mpr_mem_t          mem_cyc,
    output logic      [31:0]       n_cyc,
    output logic      [ADDR_W-1:0] last_addr,
    output logic      [DATA_W-1:0] last_wdata
);
    // ------------------------------------------------------------
    // Takes every cycle at once; counts and records it
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            n_cyc      <= '0;
            last_addr  <= '0;
            last_wdata <= '0;
        end
        else if (mem_cyc.valid)
        begin
            n_cyc     <= n_cyc + 32'h1;
            last_addr <= mem_cyc.addr;
            if (mem_cyc.write)
                last_wdata <= mem_cyc.wdata;
        end
    end
endmodule : mpr_core_model

// ### testbench.sv
// Self-checking testbench for the memory protect and relocate unit
`timescale 1ns/1ps
module testbench;
    import mpr_pkg::*;
    logic              sys_clk, rst_n, reg_wr, reg_rd, cpu_ready, cpu_trap, viol_irq, user_mode;
    logic              clk_en;
    logic [3:0]        reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, m_wdata, d;
    logic [ADDR_W-1:0] m_addr;
    logic [31:0]       n_cyc;
    mpr_req_t          cpu_req;
    mpr_mem_t          mem_cyc;
    int                n_fail, n_tests;
    logic [2:0]        causes [4] = '{3'h1, 3'h2, 3'h3, 3'h6};

    mpr_unit #(.PROT_CYCLES(4), .WR_CYCLES(22)) u_mpr_unit (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_ready(cpu_ready),
        .cpu_trap(cpu_trap), .mem_cyc(mem_cyc), .viol_irq(viol_irq), .user_mode(user_mode));
    mpr_core_model u_mpr_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .mem_cyc(mem_cyc),
        .n_cyc(n_cyc), .last_addr(m_addr), .last_wdata(m_wdata));

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [3:0] a, input logic [DATA_W-1:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(negedge sys_clk);
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [DATA_W-1:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask : reg_read

    function automatic mpr_req_t mk(input logic wr, input logic [3:0] f, input logic [16:0] a);
        mpr_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.write = wr;
        {r.io_transfer_instruction, r.halt, r.chain_xct, r.unit_access} = f;
        r.addr  = a;
        r.wdata = 18'h2a5a5;
        return r;
    endfunction : mk

    // Request held until ready or trap; answer time counted in cycles
    task automatic cpu_op(input mpr_req_t rq, input int exp_n, input logic exp_trap,
                          input logic [ADDR_W-1:0] exp_addr);
        int          n;
        logic        hit;
        logic [31:0] c0;
        c0  = n_cyc;
        n   = 0;
        hit = 1'b0;
        @(posedge sys_clk);
        cpu_req <= rq;
        while (!hit && n < 100)
        begin
            @(negedge sys_clk);
            n++;
            hit = (cpu_ready === 1'b1) || (cpu_trap === 1'b1);
        end
        if (!hit)
        begin
            $display("[ERR] %0t no answer to request", $time);
            n_fail++;
            conclude();
        end
        else
        begin
            check(n, exp_n);
            check(cpu_trap, exp_trap);
            @(posedge sys_clk);
            cpu_req.valid <= 1'b0;
            @(negedge sys_clk);
            check(mem_cyc.valid, !exp_trap);
            if (!exp_trap)
            begin
                check(mem_cyc.addr, exp_addr);
                check(mem_cyc.write, rq.write);
            end
            repeat (2) @(negedge sys_clk);
            check(n_cyc, c0 + (exp_trap ? 32'h0 : 32'h1));
        end
    endtask : cpu_op

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        reg_read(REG_BOUND, d);
        check(d, 18'h0);
        reg_read(REG_UPPER, d);
        check(d, 18'h1ff);
        reg_read(REG_RELOC, d);
        check(d, 18'h0);
        reg_read(4'hf, d);
        check(d, 18'h0);
        check(user_mode, 1'b0);
    endtask : t_reset

    task automatic t_monitor();
        reg_write(REG_BOUND, 18'h2);
        cpu_op(mk(1'b1, 4'b1000, 17'h00010), 6, 1'b0, 17'h00010);
        cpu_op(mk(1'b0, 4'b0100, 17'h00000), 6, 1'b0, 17'h00000);
        check(viol_irq, 1'b0);
    endtask : t_monitor

    // Frozen clock enable must drop a register write
    task automatic t_freeze();
        @(posedge sys_clk);
        clk_en <= 1'b0;
        reg_write(REG_BOUND, 18'h7);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        reg_read(REG_BOUND, d);
        check(d, 18'h2);
    endtask : t_freeze

    task automatic t_protect();
        reg_write(REG_CTRL, 18'h1);
        check(user_mode, 1'b1);
        cpu_op(mk(1'b1, 4'b0000, 17'h001ff), 2, 1'b1, 17'h0);
        check(user_mode, 1'b0);
        check(viol_irq, 1'b1);
        reg_read(REG_STATUS, d);
        check(d, 18'h12);
        reg_write(REG_STATUS, 18'h2);
        check(viol_irq, 1'b0);
        reg_write(REG_CTRL, 18'h1);
        cpu_op(mk(1'b1, 4'b0000, 17'h00200), 28, 1'b0, 17'h00200);
        cpu_op(mk(1'b0, 4'b0000, 17'h00200), 6, 1'b0, 17'h00200);
        check(m_wdata, 18'h2a5a5);
    endtask : t_protect

    task automatic t_priv();
        for (int i = 0; i < 4; i++)
        begin
            reg_write(REG_CTRL, 18'h1);
            cpu_op(mk(1'b0, 4'b1000 >> i, 17'h1f000), 2, 1'b1, 17'h0);
            reg_read(REG_STATUS, d);
            check(d[4:2], causes[i]);
            reg_write(REG_STATUS, 18'h2);
        end
    endtask : t_priv

    task automatic t_reloc();
        reg_write(REG_RELOC, 18'h5);
        reg_write(REG_UPPER, 18'h3);
        reg_write(REG_CTRL, 18'h3);
        cpu_op(mk(1'b0, 4'b0000, 17'h003ff), 6, 1'b0, 17'h008ff);
        cpu_op(mk(1'b0, 4'b0000, 17'h00000), 6, 1'b0, 17'h00500);
        cpu_op(mk(1'b0, 4'b0000, 17'h00400), 2, 1'b1, 17'h0);
        reg_read(REG_STATUS, d);
        check(d, 18'h16);
    endtask : t_reloc

    initial
    begin
        rst_n     = 1'b0;
        clk_en    = 1'b1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = '0;
        cpu_req   = '0;
        n_fail    = 0;
        n_tests   = 0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_monitor();
        t_freeze();
        t_protect();
        t_priv();
        t_reloc();
        conclude();
    end
endmodule : testbench
